// >>> rtl/cal_seq_defs.svh
// Contract
// - Ready output low when sequence done
// - First result comes from automatic conversion
// - Mode field returns to zero after calibration
// - Mode clears after calibration time, before ready
// - Ready adds one more period (codes 010, 011) or three more (codes 001, 100, 110, 111), plus pipeline delay
// - Code 001: self ZS+FS, 6 and 9
// - Code 010: system ZS, 3 and 4
// - Code 011: system FS, 3 and 4
// - Code 100: system ZS+internal FS, 6, 9
// - Code 101: background, never cleared, ready 6
// - Code 110: self ZS only, 3 and 6
// - Code 111: self FS only, 3 and 6
// - Result loads at first-notch rate
// - Notch rate programmable over 12-bit code
// - Three-wire port, select held low
`ifndef CAL_SEQ_DEFS_SVH
`define CAL_SEQ_DEFS_SVH

`define CLK_HZ             40000000
`define MCLK_PER_CLK       1
`define PIPE_DELAY_MCLK    2000
`define PIPE_CYCLES        (`PIPE_DELAY_MCLK * `MCLK_PER_CLK)
`define NOTCH_PRESCALE     128
`define NOTCH_CODE_W       12
`define RATE_CNT_W         19
`define PIPE_CNT_W         11
`define PER_CNT_W          4

`define MODE_NORMAL        3'h0
`define MODE_SELF          3'h1
`define MODE_SYS_ZS        3'h2
`define MODE_SYS_FS        3'h3
`define MODE_SYS_OFFSET    3'h4
`define MODE_BACKGROUND    3'h5
`define MODE_SELF_ZS       3'h6
`define MODE_SELF_FS       3'h7

`define PER_ONE_STEP       4'h3
`define PER_TWO_STEP       4'h6
`define PER_RDY_TWO_STEP   4'h9
`define PER_RDY_SYS        4'h4
`define PER_RDY_SELF_ONE   4'h6
`define PER_RDY_BG         4'h6

`define ADDR_MODE          8'h00
`define ADDR_NOTCH         8'h04
`define ADDR_DATA          8'h08
`define ADDR_STATUS        8'h0c
`define ADDR_MASK          8'h10
`define ADDR_ZS_COEF       8'h14
`define ADDR_FS_COEF       8'h18

`define MODE_F_LSB         0
`define MODE_RESTART_BIT   3
`define MODE_CHAN_LSB      4
`define STAT_BUSY_BIT      8
`define STAT_READY_BIT     9
`define STAT_SELECT_BIT    10

`define RST_NOTCH          12'h180
`define RST_ZS_COEF        24'h1f4000
`define RST_FS_COEF        24'h5761ab
`define NUM_CHAN           3

`endif

// >>> rtl/cal_seq_pkg.sv
`include "cal_seq_defs.svh"
package cal_seq_pkg;

   typedef enum logic [2:0] {
      S_NORMAL,
      S_CAL,
      S_CONV,
      S_PIPE,
      S_BG
   } seq_state_t;

   typedef struct packed {
      logic [`RATE_CNT_W-1:0] cnt;
      logic                   tick;
   } timer_regs_t;

   typedef struct packed {
      seq_state_t                     st;
      logic [2:0]                     mode;
      logic [2:0]                     kind;
      logic                           restart_bit;
      logic [1:0]                     chan;
      logic [`NOTCH_CODE_W-1:0]       notch;
      logic [`PER_CNT_W-1:0]          per;
      logic [`PIPE_CNT_W-1:0]         pipe;
      logic [23:0]                    result;
      logic                           rdy_n;
      logic [1:0]                     ists;
      logic [1:0]                     imask;
      logic [`NUM_CHAN-1:0][23:0]     zs;
      logic [`NUM_CHAN-1:0][23:0]     fs;
      logic                           wr_pend;
      logic [7:0]                     waddr;
      logic [31:0]                    rdata;
      logic [1:0]                     sel_sync;
      logic                           restart;
   } seq_regs_t;

   function automatic logic [`PER_CNT_W-1:0] clear_periods(input logic [2:0] k);
      unique case (k)
         `MODE_SELF, `MODE_SYS_OFFSET: clear_periods = `PER_TWO_STEP;
         default:                      clear_periods = `PER_ONE_STEP;
      endcase
   endfunction

   function automatic logic [`PER_CNT_W-1:0] ready_periods(input logic [2:0] k);
      unique case (k)
         `MODE_SELF, `MODE_SYS_OFFSET: ready_periods = `PER_RDY_TWO_STEP;
         `MODE_SYS_ZS, `MODE_SYS_FS:   ready_periods = `PER_RDY_SYS;
         default:                      ready_periods = `PER_RDY_SELF_ONE;
      endcase
   endfunction

   // Returns {store_fs, store_zs} for the period that has just ended
   function automatic logic [1:0] cal_store(input logic [2:0] k,
                                            input logic [`PER_CNT_W-1:0] p);
      cal_store = 2'h0;
      unique case (k)
         `MODE_SELF, `MODE_SYS_OFFSET: begin
            if (p == `PER_ONE_STEP)
               cal_store = 2'h1;
            else if (p == `PER_TWO_STEP)
               cal_store = 2'h2;
         end
         `MODE_SYS_ZS, `MODE_SELF_ZS, `MODE_BACKGROUND: begin
            if (p == `PER_ONE_STEP)
               cal_store = 2'h1;
         end
         `MODE_SYS_FS, `MODE_SELF_FS: begin
            if (p == `PER_ONE_STEP)
               cal_store = 2'h2;
         end
         default: cal_store = 2'h0;
      endcase
   endfunction

endpackage

// >>> rtl/output_rate_timer.sv
`timescale 1ns/1ps
`include "cal_seq_defs.svh"
module output_rate_timer
   import cal_seq_pkg::*;
(
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     arst_n,
   // Control
   input  wire logic                     restart,
   input  wire logic                     hold,
   input  wire logic [`NOTCH_CODE_W-1:0] notch_code,
   // Output rate strobe
   output logic                          tick
);

   timer_regs_t r_reg;
   timer_regs_t r_next;
   logic [`RATE_CNT_W-1:0] period_last;

   always_comb begin
      // A code of zero would stall the filter, so it counts as one
      period_last = `RATE_CNT_W'(`RATE_CNT_W'(`NOTCH_PRESCALE)
                    * `RATE_CNT_W'((notch_code == '0) ? 12'h001 : notch_code) - 1);
      r_next      = r_reg;
      r_next.tick = 1'b0;
      if (restart || hold) begin
         r_next.cnt = '0;
      end else if (r_reg.cnt >= period_last) begin
         r_next.cnt  = '0;
         r_next.tick = 1'b1;
      end else begin
         r_next.cnt = `RATE_CNT_W'(r_reg.cnt + 1'b1);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         r_reg <= '0;
      else
         r_reg <= r_next;
   end

   assign tick = r_reg.tick;

endmodule

// >>> rtl/adc_calibration_sequencer.sv
`timescale 1ns/1ps
`include "cal_seq_defs.svh"
module adc_calibration_sequencer
   import cal_seq_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,

   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,

   // Filter output and serial port select pin
   input  wire logic [23:0] filter_data,
   input  wire logic        serial_select_n,

   // Converter status
   output logic             result_ready_n,
   output logic             filter_tick,
   output logic             irq
);

   seq_regs_t r_reg;
   seq_regs_t r_next;

   logic       tick;
   logic       accept;
   logic [1:0] chan_idx;
   logic [1:0] store;
   logic [`PER_CNT_W-1:0] per_inc;
   logic       step;
   logic       mode_wr;

   output_rate_timer u_rate (
      .clk        (clk),
      .arst_n     (arst_n),
      .restart    (r_reg.restart),
      .hold       (r_reg.restart_bit),
      .notch_code (r_reg.notch),
      .tick       (tick)
   );

   function automatic logic [1:0] sel_chan(input logic [1:0] c);
      sel_chan = (c == 2'h3) ? 2'h2 : c;
   endfunction

   function automatic logic [31:0] read_mux(input seq_regs_t s, input logic [7:0] a);
      read_mux = 32'h0;
      unique case (a)
         `ADDR_MODE: begin
            read_mux[`MODE_F_LSB +: 3]     = s.mode;
            read_mux[`MODE_RESTART_BIT]    = s.restart_bit;
            read_mux[`MODE_CHAN_LSB +: 2]  = s.chan;
         end
         `ADDR_NOTCH:   read_mux[`NOTCH_CODE_W-1:0] = s.notch;
         `ADDR_DATA:    read_mux[23:0] = s.result;
         `ADDR_STATUS: begin
            read_mux[1:0]              = s.ists;
            read_mux[`STAT_BUSY_BIT]   = (s.st != S_NORMAL);
            read_mux[`STAT_READY_BIT]  = ~s.rdy_n;
            read_mux[`STAT_SELECT_BIT] = ~s.sel_sync[1];
         end
         `ADDR_MASK:    read_mux[1:0] = s.imask;
         `ADDR_ZS_COEF: read_mux[23:0] = s.zs[sel_chan(s.chan)];
         `ADDR_FS_COEF: read_mux[23:0] = s.fs[sel_chan(s.chan)];
         default:       read_mux = 32'h0;
      endcase
   endfunction

   always_comb begin
      r_next          = r_reg;
      r_next.restart  = 1'b0;
      r_next.wr_pend  = 1'b0;
      r_next.sel_sync = {r_reg.sel_sync[0], serial_select_n};
      accept          = hsel && htrans[1] && hready;
      chan_idx        = sel_chan(r_reg.chan);
      per_inc         = `PER_CNT_W'(r_reg.per + 1'b1);
      store           = cal_store(r_reg.kind, per_inc);
      mode_wr         = r_reg.wr_pend && (r_reg.waddr == `ADDR_MODE);
      // A tick from before a restart, or meeting a mode write, must not count a period
      step            = tick && !r_reg.restart && !mode_wr;

      // Register writes land in the data phase
      if (r_reg.wr_pend) begin
         unique case (r_reg.waddr)
            `ADDR_MODE: begin
               r_next.mode        = hwdata[`MODE_F_LSB +: 3];
               r_next.kind        = hwdata[`MODE_F_LSB +: 3];
               r_next.restart_bit = hwdata[`MODE_RESTART_BIT];
               r_next.chan        = hwdata[`MODE_CHAN_LSB +: 2];
               r_next.per         = '0;
               r_next.pipe        = '0;
               if (hwdata[`MODE_F_LSB +: 3] == `MODE_NORMAL) begin
                  r_next.st = S_NORMAL;
               end else begin
                  // Any calibration restarts the filter and retracts old data
                  r_next.restart = 1'b1;
                  r_next.rdy_n   = 1'b1;
                  r_next.st      = (hwdata[`MODE_F_LSB +: 3] == `MODE_BACKGROUND) ?
                                   S_BG : S_CAL;
               end
            end
            `ADDR_NOTCH: begin
               r_next.notch   = hwdata[`NOTCH_CODE_W-1:0];
               r_next.restart = 1'b1;
            end
            `ADDR_STATUS:  r_next.ists = r_reg.ists & ~hwdata[1:0];
            `ADDR_MASK:    r_next.imask = hwdata[1:0];
            `ADDR_ZS_COEF: r_next.zs[chan_idx] = hwdata[23:0];
            `ADDR_FS_COEF: r_next.fs[chan_idx] = hwdata[23:0];
            default: ;
         endcase
      end

      // Address phase: reads are prepared here so hrdata comes from a flop
      if (accept) begin
         r_next.waddr   = {haddr[7:2], 2'b00};
         r_next.wr_pend = hwrite;
         if (!hwrite) begin
            r_next.rdata = read_mux(r_reg, {haddr[7:2], 2'b00});
            if ({haddr[7:2], 2'b00} == `ADDR_DATA)
               r_next.rdy_n = 1'b1;
         end
      end

      // Sequencer; placed after the bus so a set beats a clear
      unique case (r_reg.st)
         S_NORMAL: begin
            if (step) begin
               r_next.result  = filter_data;
               r_next.rdy_n   = 1'b0;
               r_next.ists[1] = 1'b1;
            end
         end
         S_CAL: begin
            if (step) begin
               r_next.per = per_inc;
               if (store[0])
                  r_next.zs[chan_idx] = filter_data;
               if (store[1])
                  r_next.fs[chan_idx] = filter_data;
               if (per_inc == clear_periods(r_reg.kind)) begin
                  r_next.mode    = `MODE_NORMAL;
                  r_next.ists[0] = 1'b1;
                  r_next.st      = S_CONV;
               end
            end
         end
         S_CONV: begin
            if (step) begin
               r_next.per = per_inc;
               if (per_inc == ready_periods(r_reg.kind)) begin
                  r_next.st   = S_PIPE;
                  r_next.pipe = '0;
               end
            end
         end
         S_PIPE: begin
            if (!mode_wr && r_reg.pipe == `PIPE_CNT_W'(`PIPE_CYCLES - 1)) begin
               r_next.result  = filter_data;
               r_next.rdy_n   = 1'b0;
               r_next.ists[1] = 1'b1;
               r_next.st      = S_NORMAL;
            end else begin
               r_next.pipe = `PIPE_CNT_W'(r_reg.pipe + 1'b1);
            end
         end
         S_BG: begin
            if (step) begin
               r_next.per = per_inc;
               if (store[0])
                  r_next.zs[chan_idx] = filter_data;
               if (per_inc == `PER_RDY_BG) begin
                  r_next.per     = '0;
                  r_next.result  = filter_data;
                  r_next.rdy_n   = 1'b0;
                  r_next.ists[1] = 1'b1;
               end
            end
         end
         default: r_next.st = S_NORMAL;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r_reg          <= '0;
         r_reg.st       <= S_NORMAL;
         r_reg.notch    <= `RST_NOTCH;
         r_reg.rdy_n    <= 1'b1;
         r_reg.sel_sync <= 2'b11;
         r_reg.zs       <= {`NUM_CHAN{`RST_ZS_COEF}};
         r_reg.fs       <= {`NUM_CHAN{`RST_FS_COEF}};
      end else begin
         r_reg <= r_next;
      end
   end

   // Zero wait states; the bus never sees an error
   assign hreadyout      = 1'b1;
   assign hresp          = 1'b0;
   assign hrdata         = r_reg.rdata;
   assign result_ready_n = r_reg.rdy_n;
   assign filter_tick    = step;
   assign irq            = |(r_reg.ists & r_reg.imask);

   // select pin only reported, port assumed three-wire
   logic unused_ok;
   assign unused_ok = ^hsize;

endmodule

// >>> sim/cal_seq_chk.sv
`timescale 1ns/1ps
`include "cal_seq_defs.svh"
module cal_seq_chk (
   // Clock and reset
   input wire logic        clk,
   input wire logic        arst_n,
   // Bus
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   // Status
   input wire logic        result_ready_n,
   input wire logic        filter_tick,
   input wire logic        irq
);
   logic        take;
   logic        rd_data;
   logic        wr_q;
   logic        wr_ctl;
   logic [7:0]  addr_q;
   logic [1:0]  mask_q;
   logic [11:0] since_tick;
   assign take    = hsel && htrans[1] && hready;
   assign rd_data = take && !hwrite && haddr == `ADDR_DATA;
   // A mode write of zero leaves the timer running, so it is no restart
   assign wr_ctl  = wr_q && (addr_q == `ADDR_NOTCH ||
                             (addr_q == `ADDR_MODE && hwdata[2:0] != 3'h0));
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_q       <= 1'b0;
         addr_q     <= 8'h00;
         mask_q     <= 2'h0;
         since_tick <= 12'hfff;
      end else begin
         wr_q   <= take && hwrite;
         addr_q <= haddr;
         if (wr_q && addr_q == `ADDR_MASK)
            mask_q <= hwdata[1:0];
         if (filter_tick)
            since_tick <= 12'h000;
         else if (since_tick != 12'hfff)
            since_tick <= since_tick + 12'h001;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_bus_ok; hreadyout && !hresp; endproperty
   property p_tick_gap; filter_tick |=> !filter_tick [*8]; endproperty
   property p_ready_fall;
      $fell(result_ready_n) |-> since_tick inside {[0:2], [1998:2002]};
   endproperty
   property p_read_clr; rd_data && !filter_tick |=> result_ready_n; endproperty
   property p_cal_start;
      wr_q && addr_q == `ADDR_MODE && hwdata[2:0] != 3'h0 |=> result_ready_n [*8];
   endproperty
   property p_ready_hold;
      !result_ready_n && !rd_data && !wr_ctl |=> !result_ready_n;
   endproperty
   property p_no_early_tick; wr_ctl |=> ##1 !filter_tick [*8]; endproperty
   property p_hrdata_hold; !(take && !hwrite) |=> $stable(hrdata); endproperty
   property p_irq_mask; irq |-> mask_q != 2'h0; endproperty
   a_bus_ok: assert property (p_bus_ok) else $error("bus not ready");
   a_tick_gap: assert property (p_tick_gap) else $error("tick too wide");
   a_ready_fall: assert property (p_ready_fall) else $error("ready mistimed");
   a_read_clr: assert property (p_read_clr) else $error("read kept ready");
   a_cal_start: assert property (p_cal_start) else $error("ready early");
   a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");
   a_no_early_tick: assert property (p_no_early_tick) else $error("early tick");
   a_hrdata_hold: assert property (p_hrdata_hold) else $error("hrdata moved");
   a_irq_mask: assert property (p_irq_mask) else $error("irq unmasked");
   c_pipe: cover property ($fell(result_ready_n) && since_tick > 12'd1000);
   c_irq: cover property ($rose(irq));
   c_read: cover property (rd_data && !result_ready_n);
endmodule
bind adc_calibration_sequencer cal_seq_chk u_chk (
   .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .result_ready_n(result_ready_n),
   .filter_tick(filter_tick), .irq(irq));

// >>> sim/front_end_model.sv
`timescale 1ns/1ps
module front_end_model (
   // Clock and reset
   input  wire logic   clk,
   input  wire logic   arst_n,
   // Design side
   input  wire logic   filter_tick,
   output logic        serial_select_n,
   output logic [23:0] filter_data
);
   assign serial_select_n = 1'b0;
   // Step avoids ever matching a coefficient reset value
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         filter_data <= 24'h000101;
      else if (filter_tick)
         filter_data <= filter_data + 24'h010203;
   end
endmodule

// >>> sim/testbench.sv
`timescale 1ns/1ps
`include "cal_seq_defs.svh"
module testbench;
   import cal_seq_pkg::*;
   typedef struct packed {
      logic [2:0] code;
      logic [3:0] clr;
      logic [3:0] rdy;
   } cal_row_t;
   localparam cal_row_t ROWS [5] = '{
      '{3'h1, 4'h6, 4'h9},
      '{3'h2, 4'h3, 4'h4},
      '{3'h3, 4'h3, 4'h4},
      '{3'h6, 4'h3, 4'h6},
      '{3'h7, 4'h3, 4'h6}};
   logic        clk = 1'b0;
   logic        arst_n, hsel, hwrite, hreadyout, hresp;
   logic        result_ready_n, filter_tick, irq, serial_select_n;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rdat;
   logic [23:0] filter_data, fd;
   wire logic   hready;
   int          ticks, base, k, failures, comparisons;
   assign hready = hreadyout;
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (filter_tick === 1'b1)
         ticks <= ticks + 1;
   end
   adc_calibration_sequencer dut (
      .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .filter_data(filter_data), .serial_select_n(serial_select_n),
      .result_ready_n(result_ready_n), .filter_tick(filter_tick), .irq(irq));
   front_end_model u_fe (
      .clk(clk), .arst_n(arst_n), .filter_tick(filter_tick),
      .serial_select_n(serial_select_n), .filter_data(filter_data));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rdat = hrdata;
   endtask
   task automatic wait_ticks(input int n);
      for (int i = 0; i < 40000 && ticks - base < n; i++) @(posedge clk);
      if (ticks - base < n)
         failures++;
   endtask
   task automatic end_of_test;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #(130000 * 25);
      failures++;
      end_of_test();
   end
   initial begin
      {arst_n, hwrite, haddr, htrans, hwdata} = '0;
      {ticks, base, failures, comparisons} = '0;
      hsel  = 1'b1;
      hsize = 3'h2;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      bus(1'b1, `ADDR_NOTCH, 32'd19);
      foreach (ROWS[i]) begin
         bus(1'b1, `ADDR_MODE, 32'h10 | 32'(ROWS[i].code));
         base = ticks;
         wait_ticks(ROWS[i].clr - 1);
         bus(1'b0, `ADDR_MODE, 32'h0);
         chk(rdat & 32'h7, 32'(ROWS[i].code));
         wait_ticks(ROWS[i].clr);
         bus(1'b0, `ADDR_MODE, 32'h0);
         chk(rdat & 32'h7, 32'h0);
         chk(32'(result_ready_n), 32'h1);
         wait_ticks(ROWS[i].rdy);
         k = 0;
         do begin
            @(negedge clk);
            k++;
         end while (result_ready_n === 1'b1 && k < 4000);
         chk(k, `PIPE_CYCLES);
         fd = filter_data;
         bus(1'b0, `ADDR_DATA, 32'h0);
         chk(32'(result_ready_n), 32'h1);
         chk(rdat, 32'(fd));
      end
      bus(1'b0, `ADDR_STATUS, 32'h0);
      chk(rdat & 32'h1, 32'h1);
      chk(32'(irq), 32'h0);
      bus(1'b1, `ADDR_MASK, 32'h1);
      @(negedge clk);
      chk(32'(irq), 32'h1);
      bus(1'b1, `ADDR_STATUS, 32'h1);
      @(negedge clk);
      chk(32'(irq), 32'h0);
      // Start a two-step calibration, then abandon it
      bus(1'b1, `ADDR_MODE, 32'h14);
      base = ticks;
      wait_ticks(2);
      bus(1'b0, `ADDR_MODE, 32'h0);
      chk(rdat & 32'h7, 32'h4);
      bus(1'b1, `ADDR_MODE, 32'h15);
      base = ticks;
      wait_ticks(5);
      chk(32'(result_ready_n), 32'h1);
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (ticks - base < 6 && k < 4000);
      chk(k, `NOTCH_PRESCALE * 19);
      chk(32'(result_ready_n), 32'h0);
      bus(1'b0, `ADDR_MODE, 32'h0);
      chk(rdat & 32'h7, 32'h5);
      bus(1'b1, `ADDR_MODE, 32'h0);
      bus(1'b0, `ADDR_ZS_COEF, 32'h0);
      chk(rdat, 32'h1f4000);
      bus(1'b0, `ADDR_FS_COEF, 32'h0);
      chk(rdat, 32'h5761ab);
      bus(1'b1, `ADDR_MODE, 32'h10);
      bus(1'b0, `ADDR_ZS_COEF, 32'h0);
      chk(32'(rdat[23:0] == 24'h1f4000), 32'h0);
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      bus(1'b0, `ADDR_NOTCH, 32'h0);
      chk(rdat, 32'h180);
      bus(1'b0, `ADDR_MODE, 32'h0);
      chk(rdat, 32'h0);
      bus(1'b0, 8'h1c, 32'h0);
      chk(rdat, 32'h0);
      bus(1'b0, `ADDR_STATUS, 32'h0);
      chk(rdat & 32'h403, 32'h400);
      chk(32'(result_ready_n), 32'h1);
      end_of_test();
   end
endmodule
